// ---- rtl/amd_decoder.sv ----
// operand addressing, bit access, branch target and return stack of the core
// Functional notes
// RULE_01 - set or clear any data bit
// RULE_02 - branch on any single data bit
// RULE_03 - carry takes the addressed bit value
// RULE_04 - program, data and stack spaces kept apart
// RULE_05 - six-entry twelve-bit return stack
// RULE_06 - immediate operand is byte after opcode
// RULE_07 - direct: second byte is data address
// RULE_08 - short direct reaches 80h to 83h
// RULE_09 - extended target: opcode nibble plus byte
// RULE_10 - relative branch one byte, -15..+16
// RULE_11 - relative fields: test, direction, span
// RULE_12 - bit direct: opcode bit, byte address
// RULE_13 - bit test branch three bytes, -127..+128
// RULE_14 - indirect via pointer chosen by bit 4
// RULE_15 - inherent instructions one byte long
`default_nettype none
module amd_decoder #(
   parameter int STACK_DEPTH = amd_pkg::STACK_DEPTH_DEF
) (
   input  wire logic                         SYS_CLK_I,
   input  wire logic                         ARST_N_I,
   input  wire logic                         DEC_START_I,
   input  wire amd_pkg::amd_mode_t           MODE_I,
   input  wire logic [7:0]                   OPCODE_I,
   input  wire logic [7:0]                   BYTE2_I,
   input  wire logic [7:0]                   BYTE3_I,
   input  wire logic [amd_pkg::PC_W-1:0]     PC_I,
   input  wire logic                         FLAG_C_I,
   input  wire logic                         FLAG_Z_I,
   input  wire logic [7:0]                   DMEM_RDATA_I,
   input  wire logic                         DMEM_ACK_I,
   input  wire logic                         STACK_PUSH_I,
   input  wire logic                         STACK_POP_I,
   input  wire logic [amd_pkg::STACK_W-1:0]  STACK_DATA_I,
   output logic [7:0]                        DMEM_ADDR_O,
   output logic                              DMEM_RD_O,
   output logic                              DMEM_WR_O,
   output logic [7:0]                        DMEM_WDATA_O,
   output logic [7:0]                        OPERAND_O,
   output logic [1:0]                        LENGTH_O,
   output logic [amd_pkg::PC_W-1:0]          NEXT_PC_O,
   output logic                              BRANCH_O,
   output logic                              CARRY_LOAD_O,
   output logic                              CARRY_O,
   output logic                              DONE_O,
   output logic                              BUSY_O,
   output logic [amd_pkg::STACK_W-1:0]       STACK_TOP_O,
   output logic                              STACK_FULL_O,
   output logic                              STACK_EMPTY_O
);
   import amd_pkg::*;

   localparam int CNT_W = $clog2(STACK_DEPTH + 1);

   // a stack of one entry cannot shift; refuse it
   if (STACK_DEPTH < 2) begin : g_chk
      $error("stack depth must be at least two");
   end

   ////////////////////////////////////////////////////////////////////////////
   // decode sequencer
   amd_state_t        state,     next_state;
   amd_mode_t         mode_q,    next_mode_q;
   logic [7:0]        opc,       next_opc;
   logic [7:0]        b2,        next_b2;
   logic [7:0]        b3,        next_b3;
   logic [PC_W-1:0]   pc,        next_pc;
   logic [7:0]        next_dmem_addr;
   logic              next_dmem_rd;
   logic              next_dmem_wr;
   logic [7:0]        next_dmem_wdata;
   logic [7:0]        next_operand;
   logic [1:0]        next_length;
   logic [PC_W-1:0]   next_npc;
   logic              next_branch;
   logic              next_carry_ld;
   logic              next_carry;
   logic              next_done;
   logic              next_busy;

   // fields of the latched opcode
   logic [2:0]        bit_num;
   logic [7:0]        bit_mask;
   logic [3:0]        span;
   logic              rel_cond;
   logic [PC_W-1:0]   rel_fwd;
   logic [PC_W-1:0]   rel_bwd;
   logic [PC_W-1:0]   bt_target;
   logic              rd_bit;

   // RULE_12 opcode bit number
   assign bit_num   = opc[OPC_BIT_MSB:OPC_BIT_LSB];
   assign bit_mask  = 8'h01 << bit_num;
   assign span      = opc[OPC_SPAN_MSB:0];
   assign rel_fwd   = pc + PC_W'(span) + PC_W'(LEN1);
   assign rel_bwd   = pc - PC_W'(span);
   // displacement counts from the byte after the opcode
   assign bt_target = pc + PC_W'(LEN1) + PC_W'($signed(b3));
   assign rd_bit    = DMEM_RDATA_I[bit_num];

   // RULE_11 test type
   always_comb begin
      case (opc[OPC_TEST_MSB:OPC_TEST_LSB])
         TEST_C:  rel_cond = FLAG_C_I;
         TEST_NC: rel_cond = !FLAG_C_I;
         TEST_Z:  rel_cond = FLAG_Z_I;
         TEST_NZ: rel_cond = !FLAG_Z_I;
         default: rel_cond = 1'b0;
      endcase
   end

   // next values of the sequencer; data space reads wait for the memory ack
   always_comb begin
      next_state      = state;
      next_mode_q     = mode_q;
      next_opc        = opc;
      next_b2         = b2;
      next_b3         = b3;
      next_pc         = pc;
      next_dmem_addr  = DMEM_ADDR_O;
      next_dmem_rd    = DMEM_RD_O;
      next_dmem_wr    = 1'b0;
      next_dmem_wdata = DMEM_WDATA_O;
      next_operand    = OPERAND_O;
      next_length     = LENGTH_O;
      next_npc        = NEXT_PC_O;
      next_branch     = BRANCH_O;
      next_carry_ld   = 1'b0;
      next_carry      = CARRY_O;
      next_done       = 1'b0;
      next_busy       = BUSY_O;
      case (state)
         S_IDLE: begin
            if (DEC_START_I) begin
               next_mode_q = MODE_I;
               next_opc    = OPCODE_I;
               next_b2     = BYTE2_I;
               next_b3     = BYTE3_I;
               next_pc     = PC_I;
               next_busy   = 1'b1;
               next_branch = 1'b0;
               next_state  = S_DEC;
            end
         end
         S_DEC: begin
            next_state = S_IDLE;
            next_done  = 1'b1;
            next_busy  = 1'b0;
            case (mode_q)
               // RULE_06 immediate program byte
               M_IMM: begin
                  next_operand = b2;
                  next_length  = LEN2;
                  next_npc     = pc + PC_W'(LEN2);
               end
               // RULE_07 direct data address
               M_DIR, M_BITD, M_BITT: begin
                  next_dmem_addr = b2;
                  next_dmem_rd   = 1'b1;
                  next_length    = (mode_q == M_BITT) ? LEN3 : LEN2;
                  next_state     = S_RD;
                  next_done      = 1'b0;
                  next_busy      = 1'b1;
               end
               // RULE_08 short register select
               M_SHORT: begin
                  next_dmem_addr = SHORT_BASE | 8'(opc[OPC_SHORT_MSB:OPC_SHORT_LSB]);
                  next_dmem_rd   = 1'b1;
                  next_length    = LEN1;
                  next_state     = S_RD;
                  next_done      = 1'b0;
                  next_busy      = 1'b1;
               end
               // RULE_09 twelve-bit jump target
               M_EXT: begin
                  next_npc    = {opc[OPC_EXT_MSB:0], b2};
                  next_branch = 1'b1;
                  next_length = LEN2;
               end
               // RULE_10 one-byte relative branch
               M_REL: begin
                  next_length = LEN1;
                  next_branch = rel_cond;
                  if (!rel_cond) begin
                     next_npc = pc + PC_W'(LEN1);
                  end else if (opc[OPC_REL_DIR]) begin
                     next_npc = rel_bwd;
                  end else begin
                     next_npc = rel_fwd;
                  end
               end
               // RULE_14 pointer fetch first
               M_IND: begin
                  next_dmem_addr = PTR_BASE | 8'(opc[OPC_PTR_SEL]);
                  next_dmem_rd   = 1'b1;
                  next_length    = LEN1;
                  next_state     = S_PTR;
                  next_done      = 1'b0;
                  next_busy      = 1'b1;
               end
               // RULE_15 opcode alone
               default: begin
                  next_length = LEN1;
                  next_npc    = pc + PC_W'(LEN1);
               end
            endcase
         end
         S_PTR: begin
            // read strobe stays up; the pointer value becomes the address
            if (DMEM_ACK_I) begin
               next_dmem_addr = DMEM_RDATA_I;
               next_state     = S_RD;
            end
         end
         S_RD: begin
            if (DMEM_ACK_I) begin
               next_dmem_rd = 1'b0;
               next_operand = DMEM_RDATA_I;
               next_npc     = pc + PC_W'(LENGTH_O);
               next_state   = S_IDLE;
               next_done    = 1'b1;
               next_busy    = 1'b0;
               if (mode_q == M_BITD) begin
                  // RULE_03 carry from bit
                  next_carry_ld   = 1'b1;
                  next_carry      = rd_bit;
                  // RULE_01 read-modify-write bit
                  next_dmem_wdata = opc[OPC_BIT_COND] ? (DMEM_RDATA_I | bit_mask) : (DMEM_RDATA_I & ~bit_mask);
                  next_dmem_wr    = 1'b1;
                  next_state      = S_WR;
                  next_done       = 1'b0;
                  next_busy       = 1'b1;
               end else if (mode_q == M_BITT) begin
                  // RULE_02 tested bit shifted into carry
                  next_carry_ld = 1'b1;
                  next_carry    = rd_bit;
                  // RULE_13 branch on bit condition
                  next_branch   = (rd_bit == opc[OPC_BIT_COND]);
                  next_npc      = (rd_bit == opc[OPC_BIT_COND]) ? bt_target : pc + PC_W'(LEN3);
               end
            end
         end
         S_WR: begin
            // the write is one cycle long and needs no ack
            next_state = S_IDLE;
            next_done  = 1'b1;
            next_busy  = 1'b0;
         end
         default: begin
            next_state = S_IDLE;
            next_busy  = 1'b0;
         end
      endcase
   end

   // sequencer registers
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         state        <= S_IDLE;
         mode_q       <= M_INH;
         opc          <= 8'h00;
         b2           <= 8'h00;
         b3           <= 8'h00;
         pc           <= '0;
         DMEM_ADDR_O  <= 8'h00;
         DMEM_RD_O    <= 1'b0;
         DMEM_WR_O    <= 1'b0;
         DMEM_WDATA_O <= 8'h00;
         OPERAND_O    <= 8'h00;
         LENGTH_O     <= LEN1;
         NEXT_PC_O    <= '0;
         BRANCH_O     <= 1'b0;
         CARRY_LOAD_O <= 1'b0;
         CARRY_O      <= 1'b0;
         DONE_O       <= 1'b0;
         BUSY_O       <= 1'b0;
      end else begin
         state        <= next_state;
         mode_q       <= next_mode_q;
         opc          <= next_opc;
         b2           <= next_b2;
         b3           <= next_b3;
         pc           <= next_pc;
         DMEM_ADDR_O  <= next_dmem_addr;
         DMEM_RD_O    <= next_dmem_rd;
         DMEM_WR_O    <= next_dmem_wr;
         DMEM_WDATA_O <= next_dmem_wdata;
         OPERAND_O    <= next_operand;
         LENGTH_O     <= next_length;
         NEXT_PC_O    <= next_npc;
         BRANCH_O     <= next_branch;
         CARRY_LOAD_O <= next_carry_ld;
         CARRY_O      <= next_carry;
         DONE_O       <= next_done;
         BUSY_O       <= next_busy;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // return stack, kept apart from data space
   // RULE_04 own stack space
   logic [STACK_DEPTH*STACK_W-1:0] stk,     next_stk;
   logic [CNT_W-1:0]               cnt,     next_cnt;
   logic                           next_full;
   logic                           next_empty;

   // RULE_05 shift stack; overflow drops the oldest entry
   always_comb begin
      next_stk = stk;
      next_cnt = cnt;
      if (STACK_PUSH_I && STACK_POP_I) begin
         next_stk[STACK_W-1:0] = STACK_DATA_I;
      end else if (STACK_PUSH_I) begin
         next_stk = {stk[(STACK_DEPTH-1)*STACK_W-1:0], STACK_DATA_I};
         if (cnt != CNT_W'(STACK_DEPTH)) begin
            next_cnt = cnt + CNT_W'(1);
         end
      end else if (STACK_POP_I) begin
         next_stk = {stk[STACK_DEPTH*STACK_W-1 -: STACK_W], stk[STACK_DEPTH*STACK_W-1:STACK_W]};
         if (cnt != '0) begin
            next_cnt = cnt - CNT_W'(1);
         end
      end
      next_full  = (next_cnt == CNT_W'(STACK_DEPTH));
      next_empty = (next_cnt == '0);
   end

   // stack registers
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         stk           <= '0;
         cnt           <= '0;
         STACK_TOP_O   <= '0;
         STACK_FULL_O  <= 1'b0;
         STACK_EMPTY_O <= 1'b1;
      end else begin
         stk           <= next_stk;
         cnt           <= next_cnt;
         STACK_TOP_O   <= next_stk[STACK_W-1:0];
         STACK_FULL_O  <= next_full;
         STACK_EMPTY_O <= next_empty;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!ARST_N_I);

   logic signed [PC_W-1:0] br_off;
   assign br_off = $signed(NEXT_PC_O - pc);

   sequence s_bitd_ack;
      state == S_RD && mode_q == M_BITD && DMEM_ACK_I;
   endsequence
   sequence s_ind_ptr;
      state == S_PTR && DMEM_ACK_I;
   endsequence

   a_imm_operand: assert property (state == S_DEC && mode_q == M_IMM |=> DONE_O && OPERAND_O == b2 && LENGTH_O == LEN2) // RULE_06
      else $error("immediate operand wrong");
   a_direct_addr: assert property (state == S_DEC && mode_q == M_DIR |=> DMEM_RD_O && DMEM_ADDR_O == b2) // RULE_07
      else $error("direct address wrong");
   a_short_range: assert property (state == S_DEC && mode_q == M_SHORT |=> DMEM_ADDR_O >= 8'h80 && DMEM_ADDR_O <= 8'h83) // RULE_08
      else $error("short direct outside registers");
   a_ext_target: assert property (state == S_DEC && mode_q == M_EXT |=> BRANCH_O && NEXT_PC_O == {opc[OPC_EXT_MSB:0], b2}) // RULE_09
      else $error("extended target wrong");
   a_rel_reach: assert property (DONE_O && mode_q == M_REL && BRANCH_O |-> br_off >= REL_MIN && br_off <= REL_MAX) // RULE_10
      else $error("relative branch out of reach");
   a_rel_fall: assert property (DONE_O && mode_q == M_REL && !BRANCH_O |-> NEXT_PC_O == pc + 12'h001) // RULE_11
      else $error("relative fall-through wrong");
   a_bit_carry: assert property (s_bitd_ack |=> CARRY_LOAD_O && CARRY_O == $past(rd_bit) ##1 DONE_O) // RULE_03
      else $error("carry not loaded from bit");
   a_bit_write: assert property (s_bitd_ack |=> DMEM_WR_O && (DMEM_WDATA_O & ~bit_mask) == (OPERAND_O & ~bit_mask)
                                 && ((DMEM_WDATA_O & bit_mask) != 8'h00) == opc[OPC_BIT_COND]) // RULE_12
      else $error("bit write wrong");
   a_btest_reach: assert property (DONE_O && mode_q == M_BITT |-> LENGTH_O == LEN3
                                   && (!BRANCH_O || (br_off >= BT_MIN && br_off <= BT_MAX))) // RULE_13
      else $error("bit test branch wrong");
   a_ind_pointer: assert property (s_ind_ptr |=> DMEM_RD_O && DMEM_ADDR_O == $past(DMEM_RDATA_I)) // RULE_14
      else $error("indirect address not from pointer");
   a_inh_length: assert property (state == S_DEC && mode_q == M_INH |=> DONE_O && LENGTH_O == LEN1 && !DMEM_RD_O) // RULE_15
      else $error("inherent length wrong");
   a_stack_push: assert property (STACK_PUSH_I && !STACK_POP_I |=> STACK_TOP_O == $past(STACK_DATA_I) && !STACK_EMPTY_O) // RULE_05
      else $error("stack push lost");
endmodule : amd_decoder
`default_nettype wire

// ---- rtl/amd_decoder_unused_placeholder_removed.sv ----
// intentionally minimal: holds no logic
`default_nettype none
`default_nettype wire

// ---- shared/amd_pkg.sv ----
// constants, modes and states of the addressing mode decoder
`default_nettype none
package amd_pkg;
   localparam int PC_W            = 12;
   localparam int DATA_W          = 8;
   localparam int STACK_W         = 12;
   localparam int STACK_DEPTH_DEF = 6;

   // data space locations of the short-direct and pointer registers
   localparam logic [7:0] SHORT_BASE = 8'h80;
   localparam logic [7:0] PTR_BASE   = 8'h80;

   // opcode field positions
   localparam int OPC_PTR_SEL   = 4;
   localparam int OPC_SHORT_MSB = 3;
   localparam int OPC_SHORT_LSB = 2;
   localparam int OPC_BIT_MSB   = 7;
   localparam int OPC_BIT_LSB   = 5;
   localparam int OPC_BIT_COND  = 4;
   localparam int OPC_TEST_MSB  = 7;
   localparam int OPC_TEST_LSB  = 5;
   localparam int OPC_REL_DIR   = 4;
   localparam int OPC_SPAN_MSB  = 3;
   localparam int OPC_EXT_MSB   = 3;

   // relative test types
   localparam logic [2:0] TEST_C  = 3'h0;
   localparam logic [2:0] TEST_NC = 3'h1;
   localparam logic [2:0] TEST_Z  = 3'h2;
   localparam logic [2:0] TEST_NZ = 3'h3;

   // instruction lengths in bytes
   localparam logic [1:0] LEN1 = 2'h1;
   localparam logic [1:0] LEN2 = 2'h2;
   localparam logic [1:0] LEN3 = 2'h3;

   // reach of the two kinds of displacement
   localparam int REL_MIN = -15;
   localparam int REL_MAX = 16;
   localparam int BT_MIN  = -127;
   localparam int BT_MAX  = 128;

   typedef enum logic [8:0] {
      M_IMM   = 9'h001,
      M_DIR   = 9'h002,
      M_SHORT = 9'h004,
      M_EXT   = 9'h008,
      M_REL   = 9'h010,
      M_BITD  = 9'h020,
      M_BITT  = 9'h040,
      M_IND   = 9'h080,
      M_INH   = 9'h100
   } amd_mode_t;

   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_DEC  = 5'h02,
      S_PTR  = 5'h04,
      S_RD   = 5'h08,
      S_WR   = 5'h10
   } amd_state_t;
endpackage : amd_pkg
`default_nettype wire

// ---- tb/addressing_mode_decoder_tb_top.sv ----
// self-checking bench for the addressing mode decoder
`default_nettype none
module addressing_mode_decoder_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import amd_pkg::*;
   typedef struct packed {
      logic [7:0]  op;
      logic        chk_op;
      logic [11:0] npc;
      logic [1:0]  len;
      logic        br;
      logic        chk_c;
      logic        c;
   } amd_exp_t;
   logic        clk, rst_n, start, flag_c, flag_z, push, pop, ack, rd, wr, br, cload, carry, done, busy, full, empty;
   logic        carry_seen;
   amd_mode_t   mode;
   logic [7:0]  opc, b2, b3, rdata, addr, wdata, operand;
   logic [11:0] pc, sdata, npc, top;
   logic [1:0]  len, lat;
   logic [7:0]  shadow [256];
   amd_exp_t    expq [$];
   amd_exp_t    got_e;
   int          err_total, compares;
   int unsigned seed_v;
   ////////////////////////////////////////////////////////////
   amd_decoder amd_decoder_i (
      .SYS_CLK_I(clk), .ARST_N_I(rst_n), .DEC_START_I(start), .MODE_I(mode), .OPCODE_I(opc),
      .BYTE2_I(b2), .BYTE3_I(b3), .PC_I(pc), .FLAG_C_I(flag_c), .FLAG_Z_I(flag_z),
      .DMEM_RDATA_I(rdata), .DMEM_ACK_I(ack), .STACK_PUSH_I(push), .STACK_POP_I(pop),
      .STACK_DATA_I(sdata), .DMEM_ADDR_O(addr), .DMEM_RD_O(rd), .DMEM_WR_O(wr), .DMEM_WDATA_O(wdata),
      .OPERAND_O(operand), .LENGTH_O(len), .NEXT_PC_O(npc), .BRANCH_O(br), .CARRY_LOAD_O(cload),
      .CARRY_O(carry), .DONE_O(done), .BUSY_O(busy), .STACK_TOP_O(top), .STACK_FULL_O(full),
      .STACK_EMPTY_O(empty));
   amd_dmem_model amd_dmem_model_i (
      .clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .rd_i(rd), .wr_i(wr), .wdata_i(wdata), .lat_i(lat),
      .rdata_o(rdata), .ack_o(ack));
   // free running core clock, 50 ns period
   initial clk = 1'b0;
   always #25 clk = ~clk;
   ////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [11:0] exp_v, input logic [11:0] got_v);
      compares++;
      if (got_v !== exp_v) begin
         err_total++;
         $display("unexpected %s exp %h got %h", what, exp_v, got_v);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish
   // note the expected result, then pulse start; returns in the done cycle so the next call runs back to back
   task automatic dec(input amd_mode_t m, input logic [7:0] o, input logic [7:0] x, input logic [7:0] y,
                      input logic [11:0] p);
      amd_exp_t   e;
      logic [7:0] v;
      lat = 2'($urandom);
      flag_c = 1'($urandom);
      flag_z = 1'($urandom);
      e = '{op: 8'h00, chk_op: 1'b1, npc: p + 12'h001, len: LEN1, br: 1'b0, chk_c: 1'b0, c: 1'b0};
      v = shadow[x];
      e.c = v[o[7:5]];
      case (m)
         M_IMM, M_DIR, M_BITD: begin
            e.op = (m == M_IMM) ? x : v;
            e.len = LEN2;
            e.npc = p + 12'h002;
            e.chk_c = (m == M_BITD);
            shadow[x][o[7:5]] = (m == M_BITD) ? o[4] : v[o[7:5]];
         end
         M_SHORT: e.op = shadow[SHORT_BASE + {6'h00, o[3:2]}];
         M_IND: e.op = shadow[shadow[PTR_BASE | {7'h00, o[4]}]];
         M_REL: begin
            e.chk_op = 1'b0;
            e.br = (o[7:5] == TEST_C) ? flag_c : (o[7:5] == TEST_NC) ? !flag_c :
                   (o[7:5] == TEST_Z) ? flag_z : (o[7:5] == TEST_NZ) && !flag_z;
            e.npc = !e.br ? e.npc : o[4] ? p - {8'h00, o[3:0]} : p + 12'h001 + {8'h00, o[3:0]};
         end
         M_BITT: begin
            e.chk_op = 1'b0;
            e.chk_c = 1'b1;
            e.len = LEN3;
            e.br = (v[o[7:5]] == o[4]);
            e.npc = e.br ? p + 12'h001 + {{4{y[7]}}, y} : p + 12'h003;
         end
         M_EXT: begin
            e.chk_op = 1'b0;
            e.len = LEN2;
            e.br = 1'b1;
            e.npc = {o[3:0], x};
         end
         default: e.chk_op = 1'b0;
      endcase
      expq.push_back(e);
      mode = m;
      opc = o;
      b2 = x;
      b3 = y;
      pc = p;
      start = 1'b1;
      @(posedge clk) #5;
      start = 1'b0;
      chk("busy", 12'h001, 12'(busy));
      repeat (40) if (done !== 1'b1) @(posedge clk) #5;
   endtask : dec
   ////////////////////////////////////////////////////////////
   // compare in mid-cycle, where registered outputs have settled
   always @(negedge clk) begin
      if (cload === 1'b1) carry_seen = carry;
      if (done === 1'b1 && expq.size() == 0) begin
         err_total++;
         $display("unexpected done exp 0 got 1");
      end else if (done === 1'b1) begin
         got_e = expq.pop_front();
         chk("length", 12'(got_e.len), 12'(len));
         chk("busy_at_done", 12'h000, 12'(busy));
         chk("next_pc", got_e.npc, npc);
         chk("branch", 12'(got_e.br), 12'(br));
         if (got_e.chk_op) chk("operand", 12'(got_e.op), 12'(operand));
         if (got_e.chk_c) chk("carry", 12'(got_e.c), 12'(carry_seen));
         carry_seen = 1'bx;
      end
   end
   // main sequence
   initial begin
      {rst_n, start, flag_c, flag_z, push, pop} = '0;
      mode = M_INH;
      {opc, b2, b3, pc, sdata, lat} = '0;
      seed_v = $urandom(32'h5E77);
      for (int i = 0; i < 256; i++) shadow[i] = 8'(i) ^ 8'hA5;
      repeat (6) @(posedge clk);
      #5;
      chk("reset_length", 12'(LEN1), 12'(len));
      chk("reset_empty", 12'h001, 12'(empty));
      rst_n = 1'b1;
      @(posedge clk) #5;
      $display("test reset done");
      for (int r = 0; r < 4; r++) begin
         for (int m = 0; m < 9; m++) begin
            dec(amd_mode_t'(9'h001 << m), 8'($urandom), 8'($urandom), 8'($urandom), 12'($urandom));
         end
      end
      $display("test modes done");
      for (int i = 0; i < 32; i++) begin
         dec(M_REL, {i[4:2], i[1], {4{i[0]}}}, 8'h00, 8'h00, i[0] ? 12'hFF8 : 12'h008);
      end
      $display("test relative done");
      // clear every bit of one byte, then set them, reading back and testing after each
      for (int b = 0; b < 16; b++) begin
         dec(M_BITD, {b[2:0], b[3], 4'h0}, 8'hC3, 8'h00, 12'h7F0);
         dec(M_DIR, 8'h00, 8'hC3, 8'h00, 12'h7F0);
         dec(M_BITT, {b[2:0], b[3] ^ b[1], 4'h0}, 8'hC3, b[0] ? 8'h80 : 8'h7F, 12'h800);
      end
      $display("test bits done");
      // one push past the depth drops the oldest entry
      for (int i = 1; i <= 7; i++) begin
         push = 1'b1;
         sdata = 12'(i * 273);
         @(posedge clk) #5;
         chk("stack_top", 12'(i * 273), top);
      end
      push = 1'b0;
      chk("stack_full", 12'h001, 12'(full));
      pop = 1'b1;
      for (int i = 6; i >= 2; i--) begin
         @(posedge clk) #5;
         chk("stack_top", 12'(i * 273), top);
      end
      chk("stack_empty", 12'h000, 12'(empty));
      @(posedge clk) #5;
      pop = 1'b0;
      chk("stack_empty", 12'h001, 12'(empty));
      $display("test stack done");
      chk("pending", 12'h000, 12'(expq.size()));
      tally_and_finish();
   end
   // watchdog, well beyond the few hundred cycles the tests need
   initial begin
      repeat (6000) @(posedge clk);
      err_total++;
      $display("unexpected timeout exp done got hang");
      tally_and_finish();
   end
endmodule : addressing_mode_decoder_tb_top
`default_nettype wire

// ---- tb/amd_dmem_model.sv ----
// data-space memory model that answers the decoder's reads after a chosen wait
`default_nettype none
module amd_dmem_model (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic [7:0] addr_i,
   input  wire logic       rd_i,
   input  wire logic       wr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic [1:0] lat_i,
   output logic [7:0]      rdata_o,
   output logic            ack_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [256];
   logic [1:0] cnt;
   ////////////////////////////////////////////////////////////
   // all data locations preset
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i) ^ 8'hA5;
      end
   end
   // answer one cycle after lat_i waits; idle data toggles so a stale byte never looks valid
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_o   <= 1'b0;
         cnt     <= 2'h0;
         rdata_o <= 8'h5A;
      end else begin
         ack_o   <= 1'b0;
         rdata_o <= ~rdata_o;
         if (wr_i) begin
            mem[addr_i] <= wdata_i;
         end
         // no second answer in the ack cycle: the decoder moves its address only after it
         if (rd_i && !ack_o && cnt == lat_i) begin
            ack_o   <= 1'b1;
            rdata_o <= mem[addr_i];
            cnt     <= 2'h0;
         end else if (rd_i && !ack_o) begin
            cnt <= cnt + 2'h1;
         end else begin
            cnt <= 2'h0;
         end
      end
   end
endmodule : amd_dmem_model
`default_nettype wire
